// File: src/sr_pkg.sv
// package for the static ram host controller
package sr_pkg;
    localparam int ADDR_W = 12;
    localparam int DEPTH = 4096;
    localparam int CLK_NS = 50;
    // slowest grade access and write timing, in ns
    localparam int ACCESS_NS = 70;
    localparam int WRITE_PULSE_NS = 40;
    localparam int WRITE_REC_NS = 15;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC = (WRITE_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] CNT_ACCESS = 4'(ACCESS_CYC);
    localparam logic [3:0] CNT_WP = 4'(WP_CYC);
    localparam logic [3:0] CNT_REC = 4'(REC_CYC);

    typedef enum logic [4:0] {
        SR_IDLE = 5'h01,
        SR_RSEL = 5'h02,
        SR_WSEL = 5'h04,
        SR_WPUL = 5'h08,
        SR_DONE = 5'h10
    } sr_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic cs_n;
        logic we_n;
        logic din;
    } sr_pins_t;
endpackage

// File: src/sr_host.sv
// host controller driving a 4096 x 1 asynchronous static ram
// Summary of operation
// - for a read the host holds write strobe high while select is low and samples data.
// - the host changes address only while select or write strobe is high.
// - the host puts a valid address out no later than select falls.
// - each cycle lasts from address settled until address changes again.
`timescale 1ns/1ns
module sr_host (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // user request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [sr_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_wdata,
    output logic req_ready,
    output logic rd_valid,
    output logic rd_data,
    // memory pins
    output logic [sr_pkg::ADDR_W-1:0] word_address_lines,
    output logic cs_n,
    output logic we_n,
    output logic din,
    input wire logic dout
);
    sr_pkg::sr_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    sr_pkg::sr_pins_t pins_q, pins_d;
    logic rd_valid_q, rd_valid_d, rd_data_q, rd_data_d;

    wire cnt_done = (cnt_q == 4'h0);
    wire take = (st_q == sr_pkg::SR_IDLE) && req_valid;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_done ? 4'h0 : cnt_q - 4'h1;
        pins_d = pins_q;
        rd_valid_d = 1'b0;
        rd_data_d = rd_data_q;
        case (st_q)
            sr_pkg::SR_IDLE: begin
                pins_d.cs_n = 1'b1;
                pins_d.we_n = 1'b1;
                if (req_valid) begin
                    // address and select move together, strobes high
                    pins_d.addr = req_addr;
                    pins_d.din = req_wdata;
                    pins_d.cs_n = 1'b0;
                    if (req_write) begin
                        st_d = sr_pkg::SR_WSEL;
                        cnt_d = 4'h0;
                    end else begin
                        st_d = sr_pkg::SR_RSEL;
                        cnt_d = sr_pkg::CNT_ACCESS - 4'h1;
                    end
                end
            end
            sr_pkg::SR_RSEL: begin
                if (cnt_done) begin
                    rd_valid_d = 1'b1;
                    rd_data_d = dout;
                    pins_d.cs_n = 1'b1;
                    st_d = sr_pkg::SR_IDLE;
                end
            end
            sr_pkg::SR_WSEL: begin
                pins_d.we_n = 1'b0;
                cnt_d = sr_pkg::CNT_WP - 4'h1;
                st_d = sr_pkg::SR_WPUL;
            end
            sr_pkg::SR_WPUL: begin
                if (cnt_done) begin
                    pins_d.we_n = 1'b1;
                    cnt_d = sr_pkg::CNT_REC - 4'h1;
                    st_d = sr_pkg::SR_DONE;
                end
            end
            sr_pkg::SR_DONE: begin
                if (cnt_done) begin
                    pins_d.cs_n = 1'b1;
                    st_d = sr_pkg::SR_IDLE;
                end
            end
            default: begin
                st_d = sr_pkg::SR_IDLE;
                pins_d.cs_n = 1'b1;
                pins_d.we_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= sr_pkg::SR_IDLE;
            cnt_q <= 4'h0;
            pins_q <= '{addr: '0, cs_n: 1'b1, we_n: 1'b1, din: 1'b0};
            rd_valid_q <= 1'b0;
            rd_data_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
        end
    end

    // ready registered: high only in idle with cs_n released
    logic ready_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (st_d == sr_pkg::SR_IDLE);
        end
    end

    assign req_ready = ready_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign word_address_lines = pins_q.addr;
    assign cs_n = pins_q.cs_n;
    assign we_n = pins_q.we_n;
    assign din = pins_q.din;

    // address only changes with select or strobe high
    chk_addr_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(word_address_lines) |-> ($past(cs_n) || $past(we_n)) && we_n)
        else $error("address changed during active write");
    chk_read_strobe: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_q == sr_pkg::SR_RSEL) |-> (!cs_n && we_n))
        else $error("read cycle without strobe high");
    sequence s_wstart;
        (st_q == sr_pkg::SR_WSEL) ##1 !we_n;
    endsequence
    chk_write_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_wstart |-> !cs_n ##1 we_n[*1] ##1 cs_n)
        else $error("write pulse shape wrong");
    chk_desel_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        cs_n |-> we_n)
        else $error("strobe low while deselected");
    chk_read_done: assert property (@(posedge ref_clk) disable iff (!nrst)
        (take && !req_write) |-> ##3 rd_valid ##0 cs_n)
        else $error("read did not finish on time");
    chk_read_data: assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_valid |-> rd_data == $past(dout))
        else $error("read data not the sampled bit");
    chk_addr_setup: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(cs_n) |-> word_address_lines == $past(req_addr))
        else $error("address not valid at select fall");
    chk_idle_desel: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_q == sr_pkg::SR_IDLE) |-> cs_n)
        else $error("idle without deselect");

    // read and write cycle shapes, one step per clock
    sequence s_read_take;
        take && !req_write;
    endsequence
    sequence s_read_steps;
        (!cs_n && we_n)[*2] ##1 (cs_n && we_n && rd_valid);
    endsequence
    chk_read_shape: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_read_take |=> s_read_steps)
        else $error("read cycle shape wrong");
    sequence s_write_take;
        take && req_write;
    endsequence
    sequence s_write_steps;
        (!cs_n && we_n) ##1 (!cs_n && !we_n) ##1 (!cs_n && we_n) ##1 (cs_n && we_n);
    endsequence
    chk_write_shape: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_write_take |=> s_write_steps)
        else $error("write cycle shape wrong");

    // address and data held steady through a selected cycle
    chk_addr_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!cs_n && !$past(cs_n)) |-> $stable(word_address_lines))
        else $error("address moved while selected");
    chk_din_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!cs_n && !$past(cs_n)) |-> $stable(din))
        else $error("write data moved while selected");
    chk_busy_refuse: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_q != sr_pkg::SR_IDLE) |=> $stable(word_address_lines))
        else $error("request taken while busy");
    chk_strobe_late: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(we_n) |-> !cs_n && !$past(cs_n))
        else $error("strobe fell with select");
    chk_strobe_rec: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(we_n) |-> !cs_n)
        else $error("select rose with strobe");

    // handshake outputs
    chk_ready_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_ready |-> (st_q == sr_pkg::SR_IDLE) && cs_n && we_n)
        else $error("ready while a cycle runs");
    chk_rd_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_valid |=> !rd_valid)
        else $error("read valid longer than one cycle");
    chk_rdata_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !rd_valid |-> $stable(rd_data))
        else $error("read data moved without valid");

    // selected-cycle count, bounds every access
    logic [2:0] sel_cnt_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_cnt_q <= 3'h0;
        end else begin
            sel_cnt_q <= cs_n ? 3'h0 : sel_cnt_q + 3'h1;
        end
    end
    chk_sel_bound: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_cnt_q <= 3'h3)
        else $error("select held too long");
endmodule

// File: testbench/sr_ram_model.sv
// behavioural 4096 x 1 static ram
`timescale 1ns/1ns
module sr_ram_model (
    // memory pins
    input wire logic [sr_pkg::ADDR_W-1:0] word_address_lines,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic din,
    output logic dout
);
    logic mem [sr_pkg::DEPTH];
    wire logic rd_en = !cs_n && we_n;
    always @(cs_n, we_n, din, word_address_lines) begin
        if (!cs_n && !we_n) begin
            mem[word_address_lines] = din;
        end
    end
    // released output shows the inverse bit, never a stale copy
    assign dout = rd_en ? mem[word_address_lines] : ~mem[word_address_lines];
endmodule

// File: testbench/tb.sv
// self-checking bench for the static ram host controller
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [sr_pkg::ADDR_W-1:0] req_addr = 12'h000;
    logic req_wdata = 1'b0;
    logic req_ready, rd_valid, rd_data, cs_n, we_n, din, dout;
    logic [sr_pkg::ADDR_W-1:0] word_address_lines;
    int error_cnt = 0;
    int samples_checked = 0;
    always #25 ref_clk = ~ref_clk;
    sr_host sr_host_i (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .cs_n(cs_n),
        .word_address_lines(word_address_lines), .we_n(we_n), .din(din), .dout(dout));
    sr_ram_model sr_ram_model_i (.word_address_lines(word_address_lines), .cs_n(cs_n),
        .we_n(we_n), .din(din), .dout(dout));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #5;
            n++;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge ref_clk);
        #5;
        req_valid = 1'b0;
        chk({cs_n, we_n, word_address_lines}, {2'b01, a});
        n = 0;
        do begin
            @(posedge ref_clk);
            #5;
            n++;
            if (w && n == 1) chk({we_n, din, word_address_lines}, {1'b0, d, a});
        end while (req_ready !== 1'b1 && n < 20);
        chk(16'(n), w ? 16'h0003 : 16'h0002);
        chk({cs_n, rd_valid}, {1'b1, !w});
        if (!w) chk(rd_data, d);
    endtask
    task automatic test_reset;
        repeat (4) @(posedge ref_clk);
        #5;
        chk({cs_n, we_n, req_ready}, 3'h6);
        nrst = 1'b1;
        @(posedge ref_clk);
        #5;
        chk(req_ready, 1'b1);
        $display("test_reset done");
    endtask
    task automatic test_rw;
        logic [11:0] tbl [4] = '{12'h000, 12'hfff, 12'h555, 12'haaa};
        for (int i = 0; i < 4; i++) xfer(1'b1, tbl[i], i[0]);
        for (int i = 0; i < 4; i++) xfer(1'b0, tbl[i], i[0]);
        xfer(1'b1, 12'hfff, 1'b0);
        xfer(1'b0, 12'hfff, 1'b0);
        $display("test_rw done");
    endtask
    task automatic test_repeat;
        xfer(1'b0, 12'h555, 1'b0);
        xfer(1'b0, 12'h555, 1'b0);
        xfer(1'b0, 12'h000, 1'b0);
        $display("test_repeat done");
    endtask
    task automatic test_midreset;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 12'h123;
        req_wdata = 1'b1;
        @(posedge ref_clk);
        #5;
        req_valid = 1'b0;
        @(posedge ref_clk);
        #5;
        nrst = 1'b0;
        #1;
        chk({cs_n, we_n, req_ready, rd_valid}, 4'hc);
        @(posedge ref_clk);
        #5;
        nrst = 1'b1;
        @(posedge ref_clk);
        #5;
        chk({cs_n, we_n, req_ready}, 3'h7);
        xfer(1'b0, 12'hfff, 1'b0);
        $display("test_midreset done");
    endtask
    initial begin
        test_reset();
        test_rw();
        test_repeat();
        test_midreset();
        final_report();
    end
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule
